// ===== core/dctc_pkg.sv
// constants shared by the dual-channel torque cutoff supervisor
package dctc_pkg;

  // clock rate
  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_PER_MS = CLK_HZ / 1000;

  // channel filter: a channel is off after staying low longer than this
  localparam int FILT_TIME_MS = 2;
  localparam int FILT_CYCLES = FILT_TIME_MS * CLK_PER_MS;

  // discrepancy time before the channel mismatch alarm
  localparam int MISMATCH_TIME_S = 10;
  localparam int MISMATCH_CYCLES = MISMATCH_TIME_S * CLK_HZ;

  // brake-off delay setting counts in milliseconds
  localparam int BRK_TICK_TIME_MS = 1;
  localparam int BRK_TICK_CYCLES = BRK_TICK_TIME_MS * CLK_PER_MS;

  // counter widths
  localparam int FILT_CNT_W = 17;
  localparam int MIS_CNT_W = 28;
  localparam int TICK_CNT_W = 16;

  // register byte addresses
  localparam logic [11:0] ADDR_CONFIG = 12'h000;
  localparam logic [11:0] ADDR_CONTROL = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_ACTIVE = 12'h00c;

  // config / active field positions
  localparam int CFG_STOP_LSB = 0;
  localparam int CFG_CLR_LSB = 4;
  localparam int CFG_DLY_LSB = 8;

  // control bits
  localparam int CTRL_APPLY_BIT = 0;

  // status bits
  localparam int ST_A_ON_BIT = 0;
  localparam int ST_B_ON_BIT = 1;
  localparam int ST_CUTOFF_BIT = 2;
  localparam int ST_FMON_BIT = 3;
  localparam int ST_ALARM_BIT = 4;
  localparam int ST_SAFE_BIT = 5;
  localparam int ST_MISMATCH_BIT = 6;
  localparam int ST_STATE_LSB = 8;

  // reset values
  localparam logic [1:0] STOP_RST = 2'h0;
  localparam logic [1:0] CLR_RST = 2'h0;
  localparam logic [7:0] DLY_RST = 8'h00;

  // stop method codes
  localparam logic [1:0] STOP_DB_COAST = 2'h0;
  localparam logic [1:0] STOP_DB_HOLD = 2'h1;
  localparam logic [1:0] STOP_COAST = 2'h2;

  // deviation clear codes
  localparam logic [1:0] CLR_OFF_CUTOFF = 2'h0;
  localparam logic [1:0] CLR_WITH_OT = 2'h2;

  typedef enum logic [3:0] {
    ST_SAFE = 4'b0001,
    ST_READY = 4'b0010,
    ST_RUN = 4'b0100,
    ST_BRKDLY = 4'b1000
  } dctc_state_e;

endpackage

// ===== core/dctc_chan_filter.sv
// one safety channel: two-stage synchroniser and low-time filter
`timescale 1ns/100ps
module dctc_chan_filter #(
  parameter int FILT_CYCLES = dctc_pkg::FILT_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic chan_in,
  output logic chan_on
);
  import dctc_pkg::*;

  localparam logic [FILT_CNT_W-1:0] FILT_LIM = FILT_CNT_W'(FILT_CYCLES);

  logic sync1_q;
  logic sync2_q;
  logic [FILT_CNT_W-1:0] low_cnt_q;
  logic [FILT_CNT_W-1:0] low_cnt_d;
  logic on_q;
  logic on_d;

  // sync1_q feeds only sync2_q
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= chan_in;
      sync2_q <= sync1_q;
    end
  end

  // low pulses shorter than the filter time never reach the output
  assign low_cnt_d = sync2_q ? '0 : ((low_cnt_q == FILT_LIM) ? low_cnt_q : low_cnt_q + 1'b1);
  assign on_d = sync2_q ? 1'b1 : ((low_cnt_q == FILT_LIM) ? 1'b0 : on_q);

  // starts off so the drive comes up gated
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt_q <= '0;
      on_q <= 1'b0;
    end else begin
      low_cnt_q <= low_cnt_d;
      on_q <= on_d;
    end
  end

  assign chan_on = on_q;

endmodule // dctc_chan_filter

// ===== core/dctc_top.sv
// dual-channel torque cutoff supervisor with apb configuration
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/100ps
module dctc_top #(
  parameter int FILT_CYCLES = dctc_pkg::FILT_CYCLES,
  parameter int MISMATCH_CYCLES = dctc_pkg::MISMATCH_CYCLES,
  parameter int BRK_TICK_CYCLES = dctc_pkg::BRK_TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic safety_channel_a,
  input wire logic safety_channel_b,
  input wire logic servo_on_request,
  input wire logic motor_moving,
  input wire logic overtravel,
  output logic power_stage_enable,
  output logic failure_monitor_output,
  output logic torque_cutoff_function,
  output logic drive_ready,
  output logic brake_release_output,
  output logic dynamic_brake_enable,
  output logic deviation_clear,
  output logic alarm_state,
  output logic safe_state_indication,
  output logic channel_mismatch_alarm
);
  import dctc_pkg::*;

  localparam logic [MIS_CNT_W-1:0] MIS_LIM = MIS_CNT_W'(MISMATCH_CYCLES);
  localparam logic [TICK_CNT_W-1:0] TICK_LIM = TICK_CNT_W'(BRK_TICK_CYCLES - 1);

  // filtered channels, index 0 is channel a
  logic [1:0] chan_raw;
  logic [1:0] chan_on;
  logic a_on;
  logic b_on;

  assign chan_raw = {safety_channel_b, safety_channel_a};

  // separate filters per channel so a fault in one cannot mask the other
  for (genvar gi = 0; gi < 2; gi++) begin : g_chan
    dctc_chan_filter #(
      .FILT_CYCLES(FILT_CYCLES)
    ) dctc_chan_filter_inst (
      .pclk(pclk),
      .presetn(presetn),
      .chan_in(chan_raw[gi]),
      .chan_on(chan_on[gi])
    );
  end

  assign a_on = chan_on[0];
  assign b_on = chan_on[1];

  // channel decode
  wire both_on = a_on & b_on;
  wire both_off = ~a_on & ~b_on;
  wire one_off = a_on ^ b_on;
  // a single filtered-off channel counts as both off for cutoff
  wire cutoff_req = ~both_on;

  // apb decode
  wire apb_access = psel & penable;
  wire apb_wr = apb_access & pwrite;
  wire apb_rd = apb_access & ~pwrite;
  wire hit_config = (paddr == ADDR_CONFIG);
  wire hit_control = (paddr == ADDR_CONTROL);
  wire hit_status = (paddr == ADDR_STATUS);
  wire hit_active = (paddr == ADDR_ACTIVE);
  wire hit_any = hit_config | hit_control | hit_status | hit_active;
  wire wr_config = apb_wr & hit_config;
  wire wr_control = apb_wr & hit_control;
  wire wr_status = apb_wr & hit_status;

  // software view of configuration
  logic [1:0] cfg_stop_q;
  logic [1:0] cfg_clr_q;
  logic [7:0] cfg_dly_q;
  // settings in force; only an apply command moves them, like a restart
  logic [1:0] act_stop_q;
  logic [1:0] act_clr_q;
  logic [7:0] act_dly_q;

  wire apply_cfg = wr_control & pwdata[CTRL_APPLY_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_stop_q <= STOP_RST;
      cfg_clr_q <= CLR_RST;
      cfg_dly_q <= DLY_RST;
    end else if (wr_config) begin
      cfg_stop_q <= pwdata[CFG_STOP_LSB +: 2];
      cfg_clr_q <= pwdata[CFG_CLR_LSB +: 2];
      cfg_dly_q <= pwdata[CFG_DLY_LSB +: 8];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_stop_q <= STOP_RST;
      act_clr_q <= CLR_RST;
      act_dly_q <= DLY_RST;
    end else if (apply_cfg) begin
      act_stop_q <= cfg_stop_q;
      act_clr_q <= cfg_clr_q;
      act_dly_q <= cfg_dly_q;
    end
  end

  // mismatch timer
  logic [MIS_CNT_W-1:0] mis_cnt_q;
  logic [MIS_CNT_W-1:0] mis_cnt_d;
  logic mismatch_q;
  logic mismatch_d;

  // while set, the alarm holds the supervisor in safe state until software clears it
  wire mis_expired = one_off & (mis_cnt_q == MIS_LIM);
  wire mis_clear = wr_status & pwdata[ST_MISMATCH_BIT];

  assign mis_cnt_d = !one_off ? '0 : (mis_expired ? mis_cnt_q : mis_cnt_q + 1'b1);
  // a new expiry beats a software clear in the same cycle
  assign mismatch_d = mis_expired ? 1'b1 : (mis_clear ? 1'b0 : mismatch_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mis_cnt_q <= '0;
      mismatch_q <= 1'b0;
    end else begin
      mis_cnt_q <= mis_cnt_d;
      mismatch_q <= mismatch_d;
    end
  end

  // brake-off delay: motor stays energised after brake drops on servo off
  dctc_state_e state_q;
  dctc_state_e state_d;
  logic [TICK_CNT_W-1:0] tick_cnt_q;
  logic [TICK_CNT_W-1:0] tick_cnt_d;
  logic [7:0] dly_cnt_q;
  logic [7:0] dly_cnt_d;

  wire in_dly = (state_q == ST_BRKDLY);
  wire ms_tick = in_dly & (tick_cnt_q == TICK_LIM);
  wire dly_done = in_dly & (dly_cnt_q >= act_dly_q);

  assign tick_cnt_d = (!in_dly || ms_tick) ? '0 : tick_cnt_q + 1'b1;
  assign dly_cnt_d = !in_dly ? 8'h00 : (ms_tick ? dly_cnt_q + 8'h01 : dly_cnt_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= '0;
      dly_cnt_q <= 8'h00;
    end else begin
      tick_cnt_q <= tick_cnt_d;
      dly_cnt_q <= dly_cnt_d;
    end
  end

  // supervisor state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_SAFE: begin
        // a pending servo-on must drop first to avoid an unexpected restart
        if (both_on && !mismatch_q && !servo_on_request) begin
          state_d = ST_READY;
        end
      end
      ST_READY: begin
        if (servo_on_request) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!servo_on_request) begin
          state_d = (act_dly_q == 8'h00) ? ST_READY : ST_BRKDLY;
        end
      end
      ST_BRKDLY: begin
        if (servo_on_request) begin
          state_d = ST_RUN;
        end else if (dly_done) begin
          state_d = ST_READY;
        end
      end
      default: begin
        state_d = ST_SAFE;
      end
    endcase
    // cutoff overrides everything, including a running brake delay
    if (cutoff_req) begin
      state_d = ST_SAFE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_SAFE;
    end else begin
      state_q <= state_d;
    end
  end

  // outputs registered from the next state so cutoff acts one edge after filtering
  wire energise_d = (state_d == ST_RUN) | (state_d == ST_BRKDLY);
  wire safe_d = (state_d == ST_SAFE);
  wire stop_db = (act_stop_q == STOP_DB_HOLD) | ((act_stop_q == STOP_DB_COAST) & motor_moving);
  wire clr_ot = (act_clr_q == CLR_WITH_OT) & overtravel;
  // next values named once so the register groups below share one decode
  wire ready_d = (state_d == ST_READY);
  // the brake stays applied through the brake-off delay; only full run releases it
  wire brake_d = (state_d == ST_RUN);
  wire db_d = safe_d & stop_db;
  wire devclr_d = ~energise_d | clr_ot;

  logic pwr_q;
  logic fmon_q;
  logic cutoff_q;
  logic ready_q;
  logic brake_q;
  logic db_q;
  logic devclr_q;
  logic alarm_q;
  logic safe_ind_q;

  // drive-side outputs follow the supervisor state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_q <= 1'b0;
      cutoff_q <= 1'b1;
      ready_q <= 1'b0;
      brake_q <= 1'b0;
      db_q <= 1'b0;
      devclr_q <= 1'b1;
    end else begin
      pwr_q <= energise_d;
      cutoff_q <= safe_d;
      ready_q <= ready_d;
      brake_q <= brake_d;
      db_q <= db_d;
      devclr_q <= devclr_d;
    end
  end

  // channel-status outputs follow the filtered channels only, not the state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fmon_q <= 1'b0;
      alarm_q <= 1'b0;
      safe_ind_q <= 1'b0;
    end else begin
      fmon_q <= both_off;
      alarm_q <= one_off;
      safe_ind_q <= both_off;
    end
  end

  assign power_stage_enable = pwr_q;
  assign failure_monitor_output = fmon_q;
  assign torque_cutoff_function = cutoff_q;
  assign drive_ready = ready_q;
  assign brake_release_output = brake_q;
  assign dynamic_brake_enable = db_q;
  assign deviation_clear = devclr_q;
  assign alarm_state = alarm_q;
  assign safe_state_indication = safe_ind_q;
  assign channel_mismatch_alarm = mismatch_q;

  // read mux
  wire [31:0] config_word = {16'h0000, cfg_dly_q, 2'h0, cfg_clr_q, 2'h0, cfg_stop_q};
  wire [31:0] active_word = {16'h0000, act_dly_q, 2'h0, act_clr_q, 2'h0, act_stop_q};
  wire [31:0] status_word = {20'h00000, state_q, 1'b0, mismatch_q, safe_ind_q, alarm_q,
                             fmon_q, cutoff_q, b_on, a_on};
  logic [31:0] rd_word;

  always_comb begin
    if (hit_config) begin
      rd_word = config_word;
    end else if (hit_status) begin
      rd_word = status_word;
    end else if (hit_active) begin
      rd_word = active_word;
    end else begin
      // control is write-only and reads back zero
      rd_word = 32'h00000000;
    end
  end

  logic [31:0] prdata_q;

  // read data is captured in setup so it is stable through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= rd_word;
    end
  end

  assign prdata = apb_rd ? prdata_q : 32'h00000000;
  assign pready = 1'b1;
  // unaligned addresses miss every register and so answer with an error too
  assign pslverr = apb_access & ~hit_any;

endmodule // dctc_top

// ===== testbench/dctc_checker.sv
// concurrent checks on the torque cutoff supervisor ports
`timescale 1ns/100ps
module dctc_checker
  import dctc_pkg::*;
#(
  parameter int FILT_CYCLES = 20,
  parameter int MISMATCH_CYCLES = 200
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pslverr,
  input wire logic safety_channel_a,
  input wire logic safety_channel_b,
  input wire logic power_stage_enable,
  input wire logic failure_monitor_output,
  input wire logic torque_cutoff_function,
  input wire logic drive_ready,
  input wire logic brake_release_output,
  input wire logic dynamic_brake_enable,
  input wire logic deviation_clear,
  input wire logic alarm_state,
  input wire logic safe_state_indication,
  input wire logic channel_mismatch_alarm
);
  int any_q;
  int both_q;
  int al_q;
  int ah_q;
  int bh_q;
  // raw low-time counters; filter lag is covered by the margin of 6
  always_ff @(posedge pclk) any_q <= (!safety_channel_a || !safety_channel_b) ? any_q + 1 : 0;
  always_ff @(posedge pclk) both_q <= (!safety_channel_a && !safety_channel_b) ? both_q + 1 : 0;
  always_ff @(posedge pclk) al_q <= alarm_state ? al_q + 1 : 0;
  // raw high-time counters, held at zero in reset so the start-up filter lag is not counted
  always_ff @(posedge pclk) ah_q <= (presetn && safety_channel_a) ? ah_q + 1 : 0;
  always_ff @(posedge pclk) bh_q <= (presetn && safety_channel_b) ? bh_q + 1 : 0;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_cut_any_off: assert property (any_q > FILT_CYCLES + 6 |-> torque_cutoff_function && !power_stage_enable)
    else $error("cutoff late after a channel went off");
  a_fmon_both_off: assert property (both_q > FILT_CYCLES + 6 |-> failure_monitor_output)
    else $error("failure monitor late");
  a_fmon_match: assert property (ah_q > 5 || bh_q > 5 |-> !failure_monitor_output && !safe_state_indication)
    else $error("failure monitor on while a channel is on");
  a_alarm_excl: assert property (alarm_state |-> !failure_monitor_output && !safe_state_indication)
    else $error("alarm and safe shown together");
  a_pulse_skip: assert property ($rose(torque_cutoff_function) |-> any_q >= FILT_CYCLES)
    else $error("cutoff on a short low pulse");
  a_leave_both_on: assert property ($fell(torque_cutoff_function) |-> $past(safety_channel_a, 3) && $past(safety_channel_b, 3))
    else $error("cutoff left with a channel off");
  a_ready_not_safe: assert property (drive_ready |-> !torque_cutoff_function && !power_stage_enable)
    else $error("ready while in cutoff");
  a_brake_cut: assert property (torque_cutoff_function |-> !brake_release_output && deviation_clear)
    else $error("brake or deviation wrong in cutoff");
  a_dbrake_safe: assert property (dynamic_brake_enable |-> torque_cutoff_function)
    else $error("dynamic brake outside cutoff");
  a_mis_early: assert property ($rose(channel_mismatch_alarm) |-> al_q >= MISMATCH_CYCLES - 2)
    else $error("mismatch alarm too early");
  a_mis_late: assert property (al_q > MISMATCH_CYCLES + 2 |-> channel_mismatch_alarm)
    else $error("mismatch alarm missing");
  a_apb_unmapped: assert property (psel && penable && paddr > ADDR_ACTIVE |-> pslverr)
    else $error("no error on unmapped address");
  c_fmon: cover property ($rose(failure_monitor_output));
  c_mismatch: cover property ($rose(channel_mismatch_alarm));
  c_run: cover property ($rose(power_stage_enable));
  c_brake_delay: cover property (power_stage_enable && !brake_release_output);
endmodule // dctc_checker

// ===== testbench/dctc_safety_ctrl.sv
// safety controller model driving the two redundant channels
`timescale 1ns/100ps
module dctc_safety_ctrl (
  input wire logic pclk,
  output logic safety_channel_a,
  output logic safety_channel_b
);
  initial begin
    safety_channel_a = 1'b1;
    safety_channel_b = 1'b1;
  end
  task automatic set_ch(input logic a, input logic b);
    @(posedge pclk);
    safety_channel_a <= a;
    safety_channel_b <= b;
  endtask
  // self-test low pulse, kept below the filter time
  task automatic pulse_a(input int n);
    @(posedge pclk);
    safety_channel_a <= 1'b0;
    repeat (n) @(posedge pclk);
    safety_channel_a <= 1'b1;
  endtask
endmodule // dctc_safety_ctrl

// ===== testbench/dctc_top_bench.sv
// self-checking bench for the torque cutoff supervisor
`timescale 1ns/100ps
module dctc_top_bench;
  import dctc_pkg::*;
  localparam int FC = 20;
  localparam int MC = 200;
  localparam int WT = FC + 8;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic servo_on_request = 1'b0;
  logic motor_moving = 1'b0;
  logic overtravel = 1'b0;
  logic [31:0] prdata, r;
  logic pready, pslverr, e, safety_channel_a, safety_channel_b, power_stage_enable, failure_monitor_output;
  logic torque_cutoff_function, drive_ready, brake_release_output, dynamic_brake_enable, deviation_clear;
  logic alarm_state, safe_state_indication, channel_mismatch_alarm;
  wire logic [8:0] outs = {torque_cutoff_function, power_stage_enable, brake_release_output, alarm_state,
    failure_monitor_output, drive_ready, dynamic_brake_enable, safe_state_indication, deviation_clear};
  int err_count = 0;
  int n_compared = 0;
  always #20 pclk = ~pclk;
  dctc_top #(.FILT_CYCLES(FC), .MISMATCH_CYCLES(MC), .BRK_TICK_CYCLES(4)) dctc_top_inst (.*);
  dctc_safety_ctrl dctc_safety_ctrl_inst (.*);
  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_compared++;
    if (s !== x) begin
      err_count++;
      $display("wrong value at %0t: got %h want %h", $time, s, x);
    end
  endtask
  // one apb transfer; an idle edge after it keeps drivers single per step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    r = prdata;
    e = pslverr;
    if (i >= 50) begin
      err_count++;
      stop_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic t_reset();
    @(posedge pclk);
    chk(32'({torque_cutoff_function, power_stage_enable}), 32'h2);
    repeat (8) @(posedge pclk);
    chk(32'(outs), 32'h009);
  endtask
  task automatic t_regs();
    apb(1'b1, ADDR_CONFIG, 32'h0000_0321);
    apb(1'b0, ADDR_CONFIG, 32'h0);
    chk(r, 32'h0000_0321);
    apb(1'b0, ADDR_ACTIVE, 32'h0);
    chk(r, 32'h0);
    apb(1'b1, ADDR_CONTROL, 32'h1);
    apb(1'b0, ADDR_ACTIVE, 32'h0);
    chk(r, 32'h0000_0321);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(r, 32'h0000_0203);
    apb(1'b1, 12'h010, 32'hffff_ffff);
    chk(32'({e, r[0]}), 32'h2);
  endtask
  task automatic t_one_off();
    servo_on_request <= 1'b1;
    overtravel <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(32'({power_stage_enable, deviation_clear}), 32'h3);
    overtravel <= 1'b0;
    dctc_safety_ctrl_inst.set_ch(1'b0, 1'b1);
    repeat (WT) @(posedge pclk);
    chk(32'(outs), 32'h125);
    repeat (MC) @(posedge pclk);
    chk(32'(channel_mismatch_alarm), 32'h1);
    servo_on_request <= 1'b0;
    dctc_safety_ctrl_inst.set_ch(1'b1, 1'b1);
    repeat (8) @(posedge pclk);
    chk(32'(drive_ready), 32'h0);
    apb(1'b1, ADDR_STATUS, 32'h40);
    repeat (4) @(posedge pclk);
    chk(32'({drive_ready, torque_cutoff_function}), 32'h2);
  endtask
  task automatic t_pulse();
    servo_on_request <= 1'b1;
    repeat (4) @(posedge pclk);
    dctc_safety_ctrl_inst.pulse_a(FC - 2);
    repeat (WT) @(posedge pclk);
    chk(32'(outs), 32'h0c0);
  endtask
  task automatic t_both_off();
    dctc_safety_ctrl_inst.set_ch(1'b0, 1'b0);
    repeat (WT) @(posedge pclk);
    chk(32'(outs), 32'h117);
    servo_on_request <= 1'b0;
    // k of 3 is code 0 with the motor already stopped
    for (int k = 0; k < 4; k++) begin
      motor_moving <= (k < 3);
      apb(1'b1, ADDR_CONFIG, (k == 3) ? 32'h0 : 32'(k));
      apb(1'b1, ADDR_CONTROL, 32'h1);
      repeat (2) @(posedge pclk);
      chk(32'(dynamic_brake_enable), 32'(k < 2));
    end
    dctc_safety_ctrl_inst.set_ch(1'b1, 1'b1);
    repeat (8) @(posedge pclk);
    chk(32'(drive_ready), 32'h1);
  endtask
  // brake-off delay of 16 ticks of 4 cycles runs on servo off; a cutoff inside it removes drive at once
  task automatic t_brake_delay();
    apb(1'b1, ADDR_CONFIG, 32'h0000_1000);
    apb(1'b1, ADDR_CONTROL, 32'h1);
    servo_on_request <= 1'b1;
    overtravel <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(32'({power_stage_enable, deviation_clear}), 32'h2);
    overtravel <= 1'b0;
    servo_on_request <= 1'b0;
    repeat (4) @(posedge pclk);
    chk(32'({power_stage_enable, brake_release_output, drive_ready}), 32'h4);
    repeat (80) @(posedge pclk);
    chk(32'({power_stage_enable, drive_ready}), 32'h1);
    servo_on_request <= 1'b1;
    repeat (4) @(posedge pclk);
    servo_on_request <= 1'b0;
    dctc_safety_ctrl_inst.set_ch(1'b0, 1'b0);
    repeat (WT) @(posedge pclk);
    chk(32'({torque_cutoff_function, power_stage_enable, brake_release_output}), 32'h4);
    dctc_safety_ctrl_inst.set_ch(1'b1, 1'b1);
    repeat (8) @(posedge pclk);
    chk(32'(drive_ready), 32'h1);
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_regs();
    t_one_off();
    t_pulse();
    t_both_off();
    t_brake_delay();
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    stop_test();
  end
endmodule // dctc_top_bench
bind dctc_top dctc_checker #(.FILT_CYCLES(FILT_CYCLES), .MISMATCH_CYCLES(MISMATCH_CYCLES)) dctc_checker_inst (.*);
